/* File: bench/pss_carrier_model.sv */
// Behavioural carrier receivers and transmitters for both remote terminals
`timescale 1ns/1ns
module pss_carrier_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Scenario controls
  input  wire logic       slow,
  input  wire logic [1:0] guard_lost,
  input  wire logic [1:0] trip_key,
  input  wire logic [1:0] block_key,
  input  wire logic       cutout,
  // Transmitter contacts from the relay
  input  wire logic       start_contact,
  input  wire logic [1:0] stop_contact,
  // Receiver contacts to the relay
  output logic      [1:0] loss_of_guard,
  output logic      [1:0] permissive,
  output logic      [1:0] block_rx,
  output logic      [1:0] carrier_sent
);
  logic [7:0] stage1_reg;
  logic [7:0] stage2_reg;

  // Cutout contact keeps block receive asserted while gear is out of service
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_reg <= 8'h00;
      stage2_reg <= 8'h00;
    end else begin
      stage1_reg <= {guard_lost, trip_key, block_key | {2{cutout}}, {2{start_contact}} & ~stop_contact};
      stage2_reg <= stage1_reg;
    end
  end

  // Slow mode adds one cycle of contact delay
  always_comb begin
    {loss_of_guard, permissive, block_rx, carrier_sent} = slow ? stage2_reg : stage1_reg;
  end
endmodule

/* File: bench/pss_pilot_scheme_tb_top.sv */
// Self-checking bench for the pilot scheme logic
`timescale 1ns/1ns
module pss_pilot_scheme_tb_top;
  localparam int TC = 4;
  typedef struct packed {
    logic [31:0] mask;
    logic [31:0] val;
    logic        err;
  } pss_note_t;

  logic               pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1;
  logic               psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0000_0000;
  logic [31:0]        prdata;
  logic               pready, pslverr;
  logic [1:0]         guard_lost = 2'b00, trip_key = 2'b00, block_key = 2'b00;
  logic               cutout = 1'b0, slow = 1'b0;
  logic [1:0]         log_w, perm_w, blk_w, stop_carrier;
  pss_pkg::pss_elem_t elem = '0;
  logic               chan1_unblock_block, chan2_unblock_block, combined_unblock_block;
  logic               chan1_permissive_receive, chan2_permissive_receive, combined_permissive_receive;
  logic               level2_distance_coordinated, level2_overcurrent_coordinated;
  logic               directional_carrier_start, nondirectional_carrier_start, block_receive_extended;
  logic [12:0]        obs;
  pss_note_t          apb_q[$], out_q[$];
  int                 failures = 0, n_compared = 0, ch, first;
  event               chk_ev;

  assign obs = {chan1_unblock_block, chan2_unblock_block, combined_unblock_block, chan1_permissive_receive,
                chan2_permissive_receive, combined_permissive_receive, level2_distance_coordinated,
                level2_overcurrent_coordinated, directional_carrier_start, nondirectional_carrier_start,
                stop_carrier, block_receive_extended};

  initial begin
    forever #5 pclk = ~pclk;
  end

  pss_pilot_scheme #(.TICK_CLKS(TC)) i_pss_pilot_scheme (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan1_loss_of_guard(log_w[0]), .chan2_loss_of_guard(log_w[1]), .chan1_permissive_in(perm_w[0]),
    .chan2_permissive_in(perm_w[1]), .block_receive_in1(blk_w[0]), .block_receive_in2(blk_w[1]), .elem(elem),
    .chan1_unblock_block(chan1_unblock_block), .chan2_unblock_block(chan2_unblock_block),
    .combined_unblock_block(combined_unblock_block), .chan1_permissive_receive(chan1_permissive_receive),
    .chan2_permissive_receive(chan2_permissive_receive), .combined_permissive_receive(combined_permissive_receive),
    .level2_distance_coordinated(level2_distance_coordinated),
    .level2_overcurrent_coordinated(level2_overcurrent_coordinated),
    .directional_carrier_start(directional_carrier_start), .nondirectional_carrier_start(nondirectional_carrier_start),
    .stop_carrier(stop_carrier), .block_receive_extended(block_receive_extended));

  pss_carrier_model i_pss_carrier_model (
    .pclk(pclk), .presetn(presetn), .slow(slow), .guard_lost(guard_lost), .trip_key(trip_key),
    .block_key(block_key), .cutout(cutout), .start_contact(directional_carrier_start | nondirectional_carrier_start),
    .stop_contact(stop_carrier), .loss_of_guard(log_w), .permissive(perm_w), .block_rx(blk_w), .carrier_sent());

  task automatic wrap_up();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                     input logic [31:0] v, input logic e);
    int n;
    apb_q.push_back('{m, v, e});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20)
      failures++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic tk(input int n);
    repeat (n * TC) @(posedge pclk);
  endtask

  task automatic chk(input logic [12:0] m, input logic [12:0] v);
    @(negedge pclk);
    out_q.push_back('{{19'h0, m}, {19'h0, v}, 1'b0});
    -> chk_ev;
    @(posedge pclk);
  endtask

  task automatic cmp_apb();
    pss_note_t nt;
    nt = apb_q.pop_front();
    n_compared++;
    if (((prdata & nt.mask) !== nt.val) || (pslverr !== nt.err)) begin
      failures++;
      $display("MISMATCH %0t apb addr %h data %h err %b", $time, paddr, prdata, pslverr);
    end
  endtask

  task automatic cmp_out();
    pss_note_t nt;
    nt = out_q.pop_front();
    n_compared++;
    if ((obs & nt.mask[12:0]) !== nt.val[12:0]) begin
      failures++;
      $display("MISMATCH %0t outputs %b expected %b mask %b", $time, obs, nt.val[12:0], nt.mask[12:0]);
    end
  endtask

  always @(posedge pclk) if (psel && penable && pready) cmp_apb();
  always @(chk_ev) cmp_out();

  initial begin
    #300_000;
    failures++;
    wrap_up();
  end

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(32'h9bcf));
    @(posedge pclk);
    chk(13'h1fff, 13'h0000);
    apb(0, pss_pkg::ADDR_CTRL, 0, 32'h0000_0003, 32'h0000_0000, 0);
    apb(0, pss_pkg::ADDR_TMR_UB, 0, 32'h00ff_ffff, 32'h0002_2428, 0);
    apb(0, pss_pkg::ADDR_TMR_BLK, 0, 32'h00ff_ffff, 32'h0014_0804, 0);
    apb(0, pss_pkg::ADDR_TMR_CRD, 0, 32'h0000_ffff, 32'h0000_0404, 0);
    apb(1, 8'h14, $urandom, 32'h0000_0000, 32'h0000_0000, 1);
    apb(0, 8'h14, 0, 32'hffff_ffff, 32'h0000_0000, 1);
    // Short unblocking delays: guard 6, disable 5, declare 2 ticks
    apb(1, pss_pkg::ADDR_TMR_UB, 32'h0002_0506, 0, 0, 0);
    apb(0, pss_pkg::ADDR_TMR_UB, 0, 32'h00ff_ffff, 32'h0002_0506, 0);
    apb(1, pss_pkg::ADDR_CTRL, 32'h0000_0001, 0, 0, 0);
    guard_lost <= 2'b01;
    tk(1);
    chk(13'h1f80, 13'h0000);
    tk(4);
    chk(13'h1680, 13'h0280);
    tk(7);
    chk(13'h1680, 13'h1400);
    guard_lost <= 2'b00;
    tk(3);
    chk(13'h1400, 13'h1400);
    tk(7);
    chk(13'h1400, 13'h0000);
    trip_key <= 2'b01;
    tk(2);
    chk(13'h0280, 13'h0280);
    trip_key <= 2'b00;
    apb(1, pss_pkg::ADDR_CTRL, 32'h0000_0002, 0, 0, 0);
    first = $urandom_range(1, 0);
    for (int i = 0; i < 2; i++) begin
      ch = first ^ i;
      guard_lost <= 2'b01 << ch;
      trip_key <= 2'b10 >> ch;
      tk(5);
      chk(13'h1f80, 13'h0380);
      tk(7);
      chk(13'h1f80, ch ? 13'h0e00 : 13'h1500);
      guard_lost <= 2'b00;
      trip_key <= 2'b00;
      tk(10);
      chk(13'h1f80, 13'h0000);
    end
    block_key <= 2'b10;
    tk(3);
    chk(13'h0001, 13'h0000);
    apb(1, pss_pkg::ADDR_CTRL, 32'h0000_0003, 0, 0, 0);
    apb(1, pss_pkg::ADDR_TMR_BLK, 32'h0004_0203, 0, 0, 0);
    apb(1, pss_pkg::ADDR_TMR_CRD, 32'h0000_0302, 0, 0, 0);
    apb(0, pss_pkg::ADDR_TMR_CRD, 0, 32'h0000_ffff, 32'h0000_0302, 0);
    slow <= 1'b1;
    tk(3);
    chk(13'h0001, 13'h0001);
    block_key <= 2'b00;
    tk(1);
    chk(13'h0001, 13'h0001);
    tk(5);
    chk(13'h0001, 13'h0000);
    cutout <= 1'b1;
    tk(3);
    chk(13'h0001, 13'h0001);
    cutout <= 1'b0;
    elem <= '{level2_distance_fwd: 1'b1, level2_overcurrent_fwd: 1'b1, nondir_start_request: 1'b1, default: '0};
    tk(1);
    chk(13'h0060, 13'h0000);
    tk(5);
    chk(13'h007f, 13'h006e);
    elem <= '{level3_reverse: 4'h4, zone3_reverse: 1'b1, default: '0};
    tk(1);
    elem <= '0;
    tk(3);
    chk(13'h0010, 13'h0000);
    elem <= '{level3_reverse: 4'h4, zone3_reverse: 1'b1, default: '0};
    tk(2);
    chk(13'h0016, 13'h0010);
    tk(4);
    elem <= '0;
    tk(1);
    chk(13'h0010, 13'h0010);
    // Frozen clock enable must hold the dropout count where it is
    clk_en <= 1'b0;
    tk(10);
    clk_en <= 1'b1;
    chk(13'h0010, 13'h0010);
    tk(7);
    chk(13'h0010, 13'h0000);
    elem <= '{zone3_reverse: 1'b1, polar_memory_expired: 1'b1, current_present: 1'b1, default: '0};
    tk(2);
    elem <= '{current_present: 1'b1, default: '0};
    tk(2);
    apb(0, pss_pkg::ADDR_STATUS, 0, 32'h0000_1000, 32'h0000_1000, 0);
    elem.current_present <= 1'b0;
    tk(2);
    apb(0, pss_pkg::ADDR_STATUS, 0, 32'h0000_1000, 32'h0000_0000, 0);
    apb(1, pss_pkg::ADDR_CTRL, 32'h0000_0000, 0, 0, 0);
    tk(8);
    chk(13'h1fff, 13'h0000);
    wrap_up();
  end
endmodule

/* File: hw/pss_pilot_scheme.sv */
// Pilot scheme logic: unblocking and blocking schemes with APB settings
//
// Function
// - After channel loss, permissive returns only once guard stays healthy for guard delay.
// - Channel loss lasting the disable delay stops permissive tripping.
// - Loss of channel is declared only after it lasts the declare delay.
// - Each channel has its own timers; both share one setting per delay.
// - Two-terminal mode: channel one block asserts when loss outlasts disable delay.
// - Three-terminal mode: each channel drives its own block output.
// - Channel blocks combine per mode into one block bit; one blocks tripping.
// - Two-terminal mode: channel one permissive asserts for loss or received permissive.
// - Three-terminal mode: each channel permissive asserts for its loss or permissive.
// - Channel permissives combine per mode into one permissive bit.
// - Blocking logic works only when the scheme select chooses blocking.
// - Level-2 forward elements are delayed by coordination timers before output.
// - Reverse faults key block transmission at once, held for the reversal guard dropout time after dropout once picked up.
// - Zone-3 block is latched on memory expiry, cleared on voltage return or no current.
// - Received block is extended by a dropout timer for the extension time; the code holds it one tick less (ext_cnt > 1).
// - Reversal guard picks up after reverse condition lasts the pickup time.
// - Reversal guard holds the reverse condition for the dropout time.
// - Directional carrier start includes the reversal guard.
// - A nondirectional carrier start output is provided.
// - A stop-carrier output is provided per remote terminal.
// - Received block is the OR of both remote receiver inputs.
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ns
module pss_pilot_scheme #(
  parameter int TICK_CLKS = pss_pkg::TICK_CLKS
) (
  // Clock, reset, enable
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 clk_en,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Receiver contacts
  input  wire logic                 chan1_loss_of_guard,
  input  wire logic                 chan2_loss_of_guard,
  input  wire logic                 chan1_permissive_in,
  input  wire logic                 chan2_permissive_in,
  input  wire logic                 block_receive_in1,
  input  wire logic                 block_receive_in2,
  // Protection elements
  input  wire pss_pkg::pss_elem_t   elem,
  // Unblocking outputs
  output logic                      chan1_unblock_block,
  output logic                      chan2_unblock_block,
  output logic                      combined_unblock_block,
  output logic                      chan1_permissive_receive,
  output logic                      chan2_permissive_receive,
  output logic                      combined_permissive_receive,
  // Blocking outputs
  output logic                      level2_distance_coordinated,
  output logic                      level2_overcurrent_coordinated,
  output logic                      directional_carrier_start,
  output logic                      nondirectional_carrier_start,
  output logic [1:0]                stop_carrier,
  output logic                      block_receive_extended
);
  localparam int TW = pss_pkg::TW;

  if (TICK_CLKS < 2) begin : g_chk
    $error("TICK_CLKS must be at least 2");
  end

  function automatic logic [TW-1:0] sat_inc(input logic [TW-1:0] v);
    sat_inc = (v == {TW{1'b1}}) ? v : TW'(v + 1'b1);
  endfunction

  // Settings
  pss_pkg::pss_scheme_t scheme_reg;
  logic [TW-1:0]        guard_reg;
  logic [TW-1:0]        disable_reg;
  logic [TW-1:0]        declare_reg;
  logic [TW-1:0]        blk_ext_reg;
  logic [TW-1:0]        rev_pu_reg;
  logic [TW-1:0]        rev_do_reg;
  logic [TW-1:0]        dist_reg;
  logic [TW-1:0]        oc_reg;

  // Processing tick
  logic [31:0]          tick_cnt_reg;
  logic                 tick_reg;
  wire logic            tick_ce = tick_reg & clk_en;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg     <= 1'b0;
    end else if (clk_en) begin
      tick_reg <= (tick_cnt_reg == 32'(TICK_CLKS - 1));
      if (tick_cnt_reg == 32'(TICK_CLKS - 1)) begin
        tick_cnt_reg <= 32'h0000_0000;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // Unblocking scheme, one timer set per channel
  logic      [1:0] log_in;
  logic      [1:0] pt_in;
  wire logic [1:0] perm_next;
  wire logic [1:0] chblk_next;
  logic      [1:0] ch_en;
  assign log_in = {chan2_loss_of_guard, chan1_loss_of_guard};
  assign pt_in  = {chan2_permissive_in, chan1_permissive_in};
  assign ch_en  = {scheme_reg == pss_pkg::SCH_UNBLOCK_3,
                   scheme_reg == pss_pkg::SCH_UNBLOCK_2 || scheme_reg == pss_pkg::SCH_UNBLOCK_3};

  for (genvar ch = 0; ch < 2; ch++) begin : gen_ch
    logic [TW-1:0] dcl_cnt;
    logic [TW-1:0] dis_cnt;
    logic [TW-1:0] grd_cnt;
    logic          blk_reg;
    logic          lost;
    logic          loc;
    logic          dis_hit;
    logic          grd_hit;
    // Guard gone without a permissive tone means the channel itself failed
    assign lost    = log_in[ch] & ~pt_in[ch];
    assign loc     = lost & (dcl_cnt >= declare_reg);
    assign dis_hit = loc & (dis_cnt >= disable_reg);
    assign grd_hit = ~lost & (grd_cnt >= guard_reg);
    // Set wins: a fresh timeout beats a guard return in the same tick
    assign chblk_next[ch] = ch_en[ch] & (dis_hit | (blk_reg & ~grd_hit));
    assign perm_next[ch]  = ch_en[ch] & (pt_in[ch] | (loc & ~chblk_next[ch]));

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dcl_cnt <= '0;
        dis_cnt <= '0;
        grd_cnt <= '0;
        blk_reg <= 1'b0;
      end else if (tick_ce) begin
        dcl_cnt <= lost ? sat_inc(dcl_cnt) : '0;
        dis_cnt <= loc ? sat_inc(dis_cnt) : '0;
        grd_cnt <= (blk_reg && !lost) ? sat_inc(grd_cnt) : '0;
        blk_reg <= chblk_next[ch];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan1_unblock_block         <= 1'b0;
      chan2_unblock_block         <= 1'b0;
      combined_unblock_block      <= 1'b0;
      chan1_permissive_receive    <= 1'b0;
      chan2_permissive_receive    <= 1'b0;
      combined_permissive_receive <= 1'b0;
    end else if (tick_ce) begin
      chan1_unblock_block      <= chblk_next[0];
      chan2_unblock_block      <= chblk_next[1];
      chan1_permissive_receive <= perm_next[0];
      chan2_permissive_receive <= perm_next[1];
      // Three-terminal: either dead channel blocks, both remotes must permit
      combined_unblock_block      <= |chblk_next;
      combined_permissive_receive <= (scheme_reg == pss_pkg::SCH_UNBLOCK_3) ? &perm_next : perm_next[0];
    end
  end

  // Blocking scheme
  wire logic     blk_on  = (scheme_reg == pss_pkg::SCH_BLOCKING);
  wire logic     reverse = |elem.level3_reverse;
  wire logic     rx_any  = block_receive_in1 | block_receive_in2;
  logic [TW-1:0] dist_cnt;
  logic [TW-1:0] oc_cnt;
  logic [TW-1:0] rpu_cnt;
  logic [TW-1:0] rdo_cnt;
  logic [TW-1:0] ext_cnt;
  logic          z3_latch_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dist_cnt                       <= '0;
      oc_cnt                         <= '0;
      level2_distance_coordinated    <= 1'b0;
      level2_overcurrent_coordinated <= 1'b0;
    end else if (tick_ce) begin
      dist_cnt <= (blk_on && elem.level2_distance_fwd) ? sat_inc(dist_cnt) : '0;
      oc_cnt   <= (blk_on && elem.level2_overcurrent_fwd) ? sat_inc(oc_cnt) : '0;
      level2_distance_coordinated    <= blk_on & elem.level2_distance_fwd & (dist_cnt >= dist_reg);
      level2_overcurrent_coordinated <= blk_on & elem.level2_overcurrent_fwd & (oc_cnt >= oc_reg);
    end
  end

  // Reversal guard: pickup, then hold after the reverse elements drop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rpu_cnt <= '0;
      rdo_cnt <= '0;
    end else if (tick_ce) begin
      rpu_cnt <= (blk_on && reverse) ? sat_inc(rpu_cnt) : '0;
      if (!blk_on) begin
        rdo_cnt <= '0;
      end else if (reverse && rpu_cnt >= rev_pu_reg) begin
        rdo_cnt <= rev_do_reg;
      end else if (!reverse && rdo_cnt != '0) begin
        rdo_cnt <= rdo_cnt - 1'b1;
      end
    end
  end

  // Keeps start keyed through a close-in fault after memory runs out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      z3_latch_reg <= 1'b0;
    end else if (tick_ce) begin
      if (blk_on && elem.zone3_reverse && elem.polar_memory_expired) begin
        z3_latch_reg <= 1'b1;
      end else if (!blk_on || elem.polar_voltage_present || !elem.current_present) begin
        z3_latch_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_cnt                      <= '0;
      block_receive_extended       <= 1'b0;
      directional_carrier_start    <= 1'b0;
      nondirectional_carrier_start <= 1'b0;
      stop_carrier                 <= 2'b00;
    end else if (tick_ce) begin
      if (!blk_on) begin
        ext_cnt <= '0;
      end else if (rx_any) begin
        ext_cnt <= blk_ext_reg;
      end else if (ext_cnt != '0) begin
        ext_cnt <= ext_cnt - 1'b1;
      end
      block_receive_extended       <= blk_on & (rx_any | (ext_cnt > TW'(1)));
      directional_carrier_start    <= blk_on & (reverse | (rdo_cnt != '0) | z3_latch_reg);
      nondirectional_carrier_start <= blk_on & elem.nondir_start_request;
      // Forward fault seen and no reverse: silence both remote transmitters
      stop_carrier <= {2{blk_on & (elem.level2_distance_fwd | elem.level2_overcurrent_fwd) & ~reverse}};
    end
  end

  // APB slave, no wait states; the clock enable stalls it too
  logic       hit;
  logic [31:0] rd_word;
  always_comb begin
    hit     = 1'b1;
    rd_word = 32'h0000_0000;
    case (paddr)
      pss_pkg::ADDR_CTRL:    rd_word[pss_pkg::F_SCHEME +: 2] = scheme_reg;
      pss_pkg::ADDR_TMR_UB:  rd_word = {8'h00, declare_reg, disable_reg, guard_reg};
      pss_pkg::ADDR_TMR_BLK: rd_word = {8'h00, rev_do_reg, rev_pu_reg, blk_ext_reg};
      pss_pkg::ADDR_TMR_CRD: rd_word = {16'h0000, oc_reg, dist_reg};
      pss_pkg::ADDR_STATUS:  rd_word = {19'h0_0000, z3_latch_reg, level2_overcurrent_coordinated,
                                        level2_distance_coordinated, block_receive_extended, stop_carrier[0],
                                        nondirectional_carrier_start, directional_carrier_start,
                                        combined_permissive_receive, chan2_permissive_receive,
                                        chan1_permissive_receive, combined_unblock_block,
                                        chan2_unblock_block, chan1_unblock_block};
      default:               hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      prdata  <= (psel && !penable && !pwrite) ? rd_word : 32'h0000_0000;
    end
  end

  wire logic wr_go = clk_en & psel & penable & pready & pwrite & ~pslverr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scheme_reg  <= pss_pkg::SCH_OFF;
      guard_reg   <= pss_pkg::RST_GUARD;
      disable_reg <= pss_pkg::RST_DISABLE;
      declare_reg <= pss_pkg::RST_DECLARE;
      blk_ext_reg <= pss_pkg::RST_BLK_EXT;
      rev_pu_reg  <= pss_pkg::RST_REV_PU;
      rev_do_reg  <= pss_pkg::RST_REV_DO;
      dist_reg    <= pss_pkg::RST_DIST;
      oc_reg      <= pss_pkg::RST_OC;
    end else if (wr_go) begin
      case (paddr)
        pss_pkg::ADDR_CTRL: scheme_reg <= pss_pkg::pss_scheme_t'(pwdata[pss_pkg::F_SCHEME +: 2]);
        pss_pkg::ADDR_TMR_UB: begin
          guard_reg   <= pwdata[pss_pkg::F_GUARD +: TW];
          disable_reg <= pwdata[pss_pkg::F_DISABLE +: TW];
          declare_reg <= pwdata[pss_pkg::F_DECLARE +: TW];
        end
        pss_pkg::ADDR_TMR_BLK: begin
          blk_ext_reg <= pwdata[pss_pkg::F_BLK_EXT +: TW];
          rev_pu_reg  <= pwdata[pss_pkg::F_REV_PU +: TW];
          rev_do_reg  <= pwdata[pss_pkg::F_REV_DO +: TW];
        end
        pss_pkg::ADDR_TMR_CRD: begin
          dist_reg <= pwdata[pss_pkg::F_DIST +: TW];
          oc_reg   <= pwdata[pss_pkg::F_OC +: TW];
        end
        default: ;
      endcase
    end
  end

  // Checks
  sequence s_blk_tick;
    tick_ce && blk_on;
  endsequence
  sequence s_ch1_timeout;
    tick_ce && ch_en[0] && gen_ch[0].dis_hit;
  endsequence

  a_ch2_mode: assert property (@(posedge pclk) disable iff (!presetn)
    chan2_unblock_block || chan2_permissive_receive |-> scheme_reg == pss_pkg::SCH_UNBLOCK_3)
    else $error("channel two output outside three-terminal mode");
  a_block_combine: assert property (@(posedge pclk) disable iff (!presetn)
    combined_unblock_block == (chan1_unblock_block || chan2_unblock_block))
    else $error("combined block does not follow channel blocks");
  a_perm_combine: assert property (@(posedge pclk) disable iff (!presetn)
    combined_permissive_receive |-> chan1_permissive_receive)
    else $error("combined permissive without channel one");
  a_disable_timeout: assert property (@(posedge pclk) disable iff (!presetn)
    s_ch1_timeout |=> chan1_unblock_block && !chan1_permissive_receive || chan1_permissive_in)
    else $error("disable timeout did not block channel one");
  a_guard_release: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(chan1_unblock_block) && $past(ch_en[0]) |-> $past(gen_ch[0].grd_cnt) >= $past(guard_reg))
    else $error("block released before guard delay");
  a_declare_min: assert property (@(posedge pclk) disable iff (!presetn)
    tick_ce && gen_ch[0].loc |-> gen_ch[0].dcl_cnt >= declare_reg && gen_ch[0].lost)
    else $error("loss declared too early");
  a_blk_gated: assert property (@(posedge pclk) disable iff (!presetn)
    directional_carrier_start || block_receive_extended || stop_carrier != 2'b00 |-> blk_on)
    else $error("blocking output outside blocking mode");
  a_rev_keys: assert property (@(posedge pclk) disable iff (!presetn)
    s_blk_tick ##0 reverse |=> directional_carrier_start)
    else $error("reverse fault did not key carrier");
  a_rx_extend: assert property (@(posedge pclk) disable iff (!presetn)
    s_blk_tick ##0 (block_receive_in1 || block_receive_in2) |=> block_receive_extended [*2])
    else $error("received block not extended");
  a_z3_latch: assert property (@(posedge pclk) disable iff (!presetn)
    s_blk_tick ##0 (elem.zone3_reverse && elem.polar_memory_expired) |=> z3_latch_reg ##0 !tick_ce [*1])
    else $error("zone three latch not set");
  // Timer checks look at the count that the tick edge itself compared
  a_guard_release_two: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(chan2_unblock_block) && $past(ch_en[1]) |-> $past(gen_ch[1].grd_cnt) >= $past(guard_reg))
    else $error("channel two block released before guard delay");
  a_dist_coord: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(level2_distance_coordinated) |-> $past(dist_cnt) >= $past(dist_reg))
    else $error("distance coordination too short");
  a_oc_coord: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(level2_overcurrent_coordinated) |-> $past(oc_cnt) >= $past(oc_reg))
    else $error("overcurrent coordination too short");
  a_rev_hold: assert property (@(posedge pclk) disable iff (!presetn)
    s_blk_tick ##0 (rdo_cnt != '0) |=> directional_carrier_start)
    else $error("reversal guard hold dropped start");
  a_nondir_start: assert property (@(posedge pclk) disable iff (!presetn)
    s_blk_tick ##0 elem.nondir_start_request |=> nondirectional_carrier_start)
    else $error("nondirectional start not given");
  a_perm_follow: assert property (@(posedge pclk) disable iff (!presetn)
    tick_ce && ch_en[0] && chan1_permissive_in |=> chan1_permissive_receive)
    else $error("received permissive not passed on");
endmodule

/* File: include/pss_pkg.sv */
// Package for the pilot scheme logic: register map, fields, resets, timing
package pss_pkg;
  // Timer settings count quarter power-system cycles
  localparam int          TW            = 8;
  localparam int          TICKS_PER_CYC = 4;
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          TICK_NS       = 4_166_667;
  localparam int          TICK_CLKS     = TICK_NS / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_TMR_UB   = 8'h04;
  localparam logic [7:0]  ADDR_TMR_BLK  = 8'h08;
  localparam logic [7:0]  ADDR_TMR_CRD  = 8'h0C;
  localparam logic [7:0]  ADDR_STATUS   = 8'h10;

  // Field positions
  localparam int          F_SCHEME      = 0;
  localparam int          F_GUARD       = 0;
  localparam int          F_DISABLE     = 8;
  localparam int          F_DECLARE     = 16;
  localparam int          F_BLK_EXT     = 0;
  localparam int          F_REV_PU      = 8;
  localparam int          F_REV_DO      = 16;
  localparam int          F_DIST        = 0;
  localparam int          F_OC          = 8;

  // Reset values in ticks
  localparam logic [TW-1:0] RST_GUARD   = 8'h28;
  localparam logic [TW-1:0] RST_DISABLE = 8'h24;
  localparam logic [TW-1:0] RST_DECLARE = 8'h02;
  localparam logic [TW-1:0] RST_BLK_EXT = 8'h04;
  localparam logic [TW-1:0] RST_REV_PU  = 8'h08;
  localparam logic [TW-1:0] RST_REV_DO  = 8'h14;
  localparam logic [TW-1:0] RST_DIST    = 8'h04;
  localparam logic [TW-1:0] RST_OC      = 8'h04;

  typedef enum logic [1:0] {
    SCH_OFF       = 2'b00,
    SCH_UNBLOCK_2 = 2'b01,
    SCH_UNBLOCK_3 = 2'b10,
    SCH_BLOCKING  = 2'b11
  } pss_scheme_t;

  // Protection element inputs used by the blocking scheme
  typedef struct packed {
    logic       level2_distance_fwd;
    logic       level2_overcurrent_fwd;
    logic [3:0] level3_reverse;
    logic       zone3_reverse;
    logic       polar_memory_expired;
    logic       polar_voltage_present;
    logic       current_present;
    logic       nondir_start_request;
  } pss_elem_t;
endpackage
